// [include/wos_map.vh]
`ifndef WOS_MAP_VH
`define WOS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define WOS_REG_CTRL     8'h00
`define WOS_REG_SRC_SEL  8'h04
`define WOS_REG_DIVISOR  8'h08
`define WOS_REG_DELAY    8'h0c
`define WOS_REG_COUNT    8'h10
`define WOS_REG_DATA     8'h14
`define WOS_REG_STATUS   8'h18
`define WOS_REG_ISSUED   8'h1c

////////////////////////////////////////////////////////////////////////////////
// control register: command bits (self clearing)
`define WOS_CTL_ARM       0
`define WOS_CTL_SW_START  1
`define WOS_CTL_STOP      2
`define WOS_CTL_SW_UPDATE 3
`define WOS_CTL_CLR_ERR   13
`define WOS_CTL_FLUSH     14
// control register: stored fields
`define WOS_CTL_MODE_LO   4
`define WOS_CTL_MODE_HI   5
`define WOS_CTL_CONT      6
`define WOS_CTL_REGEN_LO  8
`define WOS_CTL_REGEN_HI  9
`define WOS_CTL_TRIG_FALL 10
`define WOS_CTL_STRB_FALL 11
`define WOS_CTL_HOLD_LOW  12
`define WOS_CTL_STORE_MSK 32'h0000_1f70

////////////////////////////////////////////////////////////////////////////////
// source select fields, code 0 means software / none / internal divider
`define WOS_SEL_BEGIN_LO  0
`define WOS_SEL_HOLD_LO   8
`define WOS_SEL_STRB_LO   16
`define WOS_SEL_STORE_MSK 32'h001f_1f1f

////////////////////////////////////////////////////////////////////////////////
// encodings
`define WOS_MODE_SW       2'h0
`define WOS_MODE_NB       2'h1
`define WOS_MODE_BUF      2'h2
`define WOS_REGEN_STD     2'h0
`define WOS_REGEN_LOCAL   2'h1
`define WOS_REGEN_NONE    2'h2
`define WOS_RESP_OKAY     2'h0
`define WOS_RESP_SLVERR   2'h2

////////////////////////////////////////////////////////////////////////////////
// reset values
`define WOS_CTRL_RST      32'h0000_0000
`define WOS_SEL_RST       32'h0000_0000
`define WOS_DIVISOR_RST   32'h0000_0014
`define WOS_DELAY_RST     32'h0000_0002
`define WOS_COUNT_RST     32'h0000_0000

`endif

// [design/wos_queue_mem.v]
module wos_queue_mem #(
	parameter AW = 8,
	parameter DW = 32
) (
	input  wire          aclk,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// registered read; a word written at edge n is seen from edge n+1
	always @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // wos_queue_mem

// [design/wos_strobe_gen.v]
module wos_strobe_gen #(
	parameter CW = 32
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire          start,
	input  wire          run,
	input  wire          hold,
	input  wire          ext_sel,
	input  wire          ext_in,
	input  wire          edge_fall,
	input  wire          timebase,
	input  wire [CW-1:0] divisor,
	input  wire [CW-1:0] first_delay,
	output reg           strobe
);

	reg          tb_prev_q;
	reg          ext_prev_q;
	reg [CW-1:0] cnt_q;
	wire         tb_tick;
	wire         ext_edge;

	assign tb_tick  = timebase & ~tb_prev_q;
	assign ext_edge = edge_fall ? (ext_prev_q & ~ext_in) : (ext_in & ~ext_prev_q);

	always @(posedge aclk) begin
		if (!aresetn) begin
			tb_prev_q  <= 1'b0;
			ext_prev_q <= 1'b0;
			cnt_q      <= {CW{1'b0}};
			strobe     <= 1'b0;
		end else begin
			tb_prev_q  <= timebase;
			ext_prev_q <= ext_in;
			strobe     <= 1'b0;
			if (start) begin
				cnt_q <= first_delay;
			end else if (run && !hold) begin
				if (ext_sel) begin
					// edges seen while held are dropped: resume waits for a fresh edge
					strobe <= ext_edge;
				end else if (tb_tick) begin
					// counter frozen while held, so it picks up at once on release
					if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
						strobe <= 1'b1;
						cnt_q  <= divisor;
					end else begin
						cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end

endmodule // wos_strobe_gen

// [design/wos_top.v]
`include "wos_map.vh"

module wos_top #(
	parameter AW = 8,
	parameter CW = 16
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire [5:0]    pft_in,
	input  wire [7:0]    trig_bus_in,
	input  wire          acq_stop_reference_trigger,
	input  wire          acq_begin_trigger,
	input  wire          star_trigger,
	input  wire [3:0]    internal_trigger,
	input  wire          gen_strobe_timebase,
	output reg  [2*CW-1:0] chan_code,
	output reg           conv_update,
	output reg           gen_begin_trigger,
	output reg           gen_hold_trigger,
	output wire          gen_sample_strobe
);

	localparam ST_IDLE  = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_RUN   = 3'b100;
	localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

	////////////////////////////////////////////////////////////////////////////
	// bus slave state
	reg        aw_hold_q;
	reg        w_hold_q;
	reg [7:0]  wr_addr_q;
	reg [31:0] wr_data_q;
	reg [3:0]  wr_strb_q;
	reg [31:0] ctrl_q;
	reg [31:0] sel_q;
	reg [31:0] divisor_q;
	reg [31:0] delay_q;
	reg [31:0] count_q;
	reg [31:0] staging_q;
	reg [31:0] rd_mux;
	reg        rd_ok;
	reg        wr_ok;
	wire       wr_commit;
	wire [31:0] wmask;
	wire [7:0] wa;
	wire [7:0] ra;

	////////////////////////////////////////////////////////////////////////////
	// sequencer state
	reg [2:0]  state_q;
	reg        load_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] base_ptr_q;
	reg [AW:0] qcnt_q;
	reg        locked_q;
	reg        underflow_q;
	reg        refused_q;
	reg [31:0] issued_q;
	reg        begin_prev_q;
	wire [31:0] src_vec;
	wire [1:0] mode;
	wire [1:0] regen;
	wire [4:0] begin_sel;
	wire [4:0] hold_sel;
	wire [4:0] strb_sel;
	wire       ctl_wr;
	wire       data_wr;
	wire       cmd_arm;
	wire       cmd_start;
	wire       cmd_stop;
	wire       cmd_update;
	wire       cmd_clr;
	wire       cmd_flush;
	wire       begin_src;
	wire       begin_edge;
	wire       begin_fire;
	wire       hold_act;
	wire       strobe;
	wire       issue;
	wire       q_empty;
	wire       q_full;
	wire       push;
	wire       refuse;
	wire       pop;
	wire       starve;
	wire       upd_evt;
	wire       last;
	wire       rd_wrap;
	wire [31:0] mem_rdata;
	wire [31:0] upd_word;
	wire       upd_now;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	assign wr_commit = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign wmask = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}}, {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
	assign wa = {wr_addr_q[7:2], 2'b00};
	assign ra = {s_axi_araddr[7:2], 2'b00};

	always @* begin
		wr_ok = (wa == `WOS_REG_CTRL) | (wa == `WOS_REG_SRC_SEL) | (wa == `WOS_REG_DIVISOR) |
			(wa == `WOS_REG_DELAY) | (wa == `WOS_REG_COUNT) | (wa == `WOS_REG_DATA) |
			(wa == `WOS_REG_STATUS) | (wa == `WOS_REG_ISSUED);
	end

	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		case (ra)
			`WOS_REG_CTRL:    rd_mux = ctrl_q;
			`WOS_REG_SRC_SEL: rd_mux = sel_q;
			`WOS_REG_DIVISOR: rd_mux = divisor_q;
			`WOS_REG_DELAY:   rd_mux = delay_q;
			`WOS_REG_COUNT:   rd_mux = count_q;
			`WOS_REG_DATA:    rd_mux = staging_q;
			`WOS_REG_STATUS:  rd_mux = {{(15-AW){1'b0}}, qcnt_q, 9'h000, refused_q, locked_q,
				q_full, q_empty, underflow_q, state_q[2], state_q[1]};
			`WOS_REG_ISSUED:  rd_mux = issued_q;
			default:          rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `WOS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `WOS_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			wr_addr_q     <= 8'h00;
			wr_data_q     <= 32'h0000_0000;
			wr_strb_q     <= 4'h0;
			ctrl_q        <= `WOS_CTRL_RST;
			sel_q         <= `WOS_SEL_RST;
			divisor_q     <= `WOS_DIVISOR_RST;
			delay_q       <= `WOS_DELAY_RST;
			count_q       <= `WOS_COUNT_RST;
			staging_q     <= 32'h0000_0000;
		end else begin
			// ready is a one-cycle pulse; address and data are held until both arrive
			s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_hold_q & ~s_axi_bvalid;
			s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_hold_q & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				wr_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q  <= 1'b1;
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			if (wr_commit) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `WOS_RESP_OKAY : `WOS_RESP_SLVERR;
				case (wa)
					`WOS_REG_CTRL:    ctrl_q <= (ctrl_q & ~(wmask & `WOS_CTL_STORE_MSK)) |
						(wr_data_q & wmask & `WOS_CTL_STORE_MSK);
					`WOS_REG_SRC_SEL: sel_q <= (sel_q & ~(wmask & `WOS_SEL_STORE_MSK)) |
						(wr_data_q & wmask & `WOS_SEL_STORE_MSK);
					`WOS_REG_DIVISOR: divisor_q <= (divisor_q & ~wmask) | (wr_data_q & wmask);
					`WOS_REG_DELAY:   delay_q <= (delay_q & ~wmask) | (wr_data_q & wmask);
					`WOS_REG_COUNT:   count_q <= (count_q & ~wmask) | (wr_data_q & wmask);
					`WOS_REG_DATA:    staging_q <= (staging_q & ~wmask) | (wr_data_q & wmask);
					default:          staging_q <= staging_q;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? `WOS_RESP_OKAY : `WOS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// commands, trigger sources
	assign ctl_wr     = wr_commit & (wa == `WOS_REG_CTRL);
	assign data_wr    = wr_commit & (wa == `WOS_REG_DATA);
	assign cmd_arm    = ctl_wr & wr_data_q[`WOS_CTL_ARM];
	assign cmd_start  = ctl_wr & wr_data_q[`WOS_CTL_SW_START];
	assign cmd_stop   = ctl_wr & wr_data_q[`WOS_CTL_STOP];
	assign cmd_update = ctl_wr & wr_data_q[`WOS_CTL_SW_UPDATE];
	assign cmd_clr    = ctl_wr & wr_data_q[`WOS_CTL_CLR_ERR];
	assign cmd_flush  = ctl_wr & wr_data_q[`WOS_CTL_FLUSH];
	assign mode       = ctrl_q[`WOS_CTL_MODE_HI:`WOS_CTL_MODE_LO];
	assign regen      = ctrl_q[`WOS_CTL_REGEN_HI:`WOS_CTL_REGEN_LO];
	assign begin_sel  = sel_q[`WOS_SEL_BEGIN_LO+4:`WOS_SEL_BEGIN_LO];
	assign hold_sel   = sel_q[`WOS_SEL_HOLD_LO+4:`WOS_SEL_HOLD_LO];
	assign strb_sel   = sel_q[`WOS_SEL_STRB_LO+4:`WOS_SEL_STRB_LO];

	// only digital levels enter here; code 0 is the software / none slot
	assign src_vec = {10'h000, internal_trigger, star_trigger, acq_begin_trigger,
		acq_stop_reference_trigger, trig_bus_in, pft_in, 1'b0};
	assign begin_src  = src_vec[begin_sel];
	assign begin_edge = ctrl_q[`WOS_CTL_TRIG_FALL] ? (begin_prev_q & ~begin_src) :
		(begin_src & ~begin_prev_q);
	assign begin_fire = state_q[1] & ((begin_sel == 5'h00) ? cmd_start : begin_edge);
	// level sensitive only, polarity chosen by software
	assign hold_act   = (hold_sel != 5'h00) & (src_vec[hold_sel] ^ ctrl_q[`WOS_CTL_HOLD_LOW]);

	wos_strobe_gen #(
		.CW          (32)
	) u_strobe (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (begin_fire),
		.run         (state_q[2]),
		.hold        (hold_act),
		.ext_sel     (strb_sel != 5'h00),
		.ext_in      (src_vec[strb_sel]),
		.edge_fall   (ctrl_q[`WOS_CTL_STRB_FALL]),
		.timebase    (gen_strobe_timebase),
		.divisor     (divisor_q),
		.first_delay (delay_q),
		.strobe      (strobe)
	);
	assign gen_sample_strobe = strobe;

	////////////////////////////////////////////////////////////////////////////
	// sample queue
	assign q_empty = (qcnt_q == {(AW+1){1'b0}});
	assign q_full  = (qcnt_q == DEPTH);
	assign issue   = state_q[2] & strobe & (mode != `WOS_MODE_SW) & ~load_q;
	assign push    = data_wr & (mode == `WOS_MODE_BUF) & ~locked_q & ~q_full;
	assign refuse  = data_wr & (mode == `WOS_MODE_BUF) & (locked_q | q_full);
	assign pop     = load_q & ~locked_q;
	assign starve  = issue & (mode == `WOS_MODE_BUF) & q_empty;
	assign upd_evt = (issue & (mode == `WOS_MODE_NB)) | load_q;
	assign last    = ~ctrl_q[`WOS_CTL_CONT] & ((issued_q + 32'h0000_0001) >= count_q);
	assign rd_wrap = (rd_ptr_q + {{(AW-1){1'b0}}, 1'b1}) == wr_ptr_q;

	wos_queue_mem #(
		.AW      (AW),
		.DW      (32)
	) u_mem (
		.aclk    (aclk),
		.wr_en   (push),
		.wr_addr (wr_ptr_q),
		.wr_data ((staging_q & ~wmask) | (wr_data_q & wmask)),
		.rd_addr (rd_ptr_q),
		.rd_data (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q           <= ST_IDLE;
			load_q            <= 1'b0;
			rd_ptr_q          <= {AW{1'b0}};
			wr_ptr_q          <= {AW{1'b0}};
			base_ptr_q        <= {AW{1'b0}};
			qcnt_q            <= {(AW+1){1'b0}};
			locked_q          <= 1'b0;
			underflow_q       <= 1'b0;
			refused_q         <= 1'b0;
			issued_q          <= 32'h0000_0000;
			begin_prev_q      <= 1'b0;
			gen_begin_trigger <= 1'b0;
			gen_hold_trigger  <= 1'b0;
		end else begin
			begin_prev_q      <= begin_src;
			gen_begin_trigger <= begin_fire;
			gen_hold_trigger  <= hold_act;
			// a pending load always finishes, even across a pause or a stop
			load_q <= issue & (mode == `WOS_MODE_BUF) & ~q_empty;
			// a new event in the clearing cycle wins
			underflow_q <= (starve & (regen == `WOS_REGEN_NONE | ~ctrl_q[`WOS_CTL_CONT])) |
				(underflow_q & ~cmd_clr);
			refused_q <= refuse | (refused_q & ~cmd_clr);
			if (upd_evt) begin
				issued_q <= issued_q + 32'h0000_0001;
			end
			if (cmd_flush && state_q[0]) begin
				rd_ptr_q <= {AW{1'b0}};
				wr_ptr_q <= {AW{1'b0}};
				qcnt_q   <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
				end
				if (load_q) begin
					if (locked_q && rd_wrap) begin
						rd_ptr_q <= base_ptr_q;
					end else begin
						rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
					end
				end
				qcnt_q <= qcnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			end
			case (state_q)
				ST_IDLE: begin
					if (cmd_arm && mode != `WOS_MODE_SW) begin
						state_q <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (cmd_stop) begin
						state_q <= ST_IDLE;
					end else if (begin_fire) begin
						state_q    <= ST_RUN;
						issued_q   <= 32'h0000_0000;
						base_ptr_q <= rd_ptr_q;
						locked_q   <= (mode == `WOS_MODE_BUF) & (regen == `WOS_REGEN_LOCAL);
					end
				end
				ST_RUN: begin
					// continuous runs end only here or on underflow
					if (cmd_stop) begin
						state_q  <= ST_IDLE;
						locked_q <= 1'b0;
					end else if (starve &&
						(regen == `WOS_REGEN_NONE || !ctrl_q[`WOS_CTL_CONT])) begin
						state_q  <= ST_IDLE;
						locked_q <= 1'b0;
					end else if (upd_evt && last) begin
						state_q  <= ST_IDLE;
						locked_q <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// converter outputs: one word feeds both channels on the same edge
	assign upd_now  = (cmd_update & (mode == `WOS_MODE_SW)) | (issue & (mode == `WOS_MODE_NB)) |
		load_q;
	assign upd_word = load_q ? mem_rdata : staging_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			conv_update <= 1'b0;
		end else begin
			conv_update <= upd_now;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			always @(posedge aclk) begin
				if (!aresetn) begin
					chan_code[ch*CW +: CW] <= {CW{1'b0}};
				end else if (upd_now) begin
					chan_code[ch*CW +: CW] <= upd_word[ch*CW +: CW];
				end
			end
		end
	endgenerate

endmodule // wos_top

// [tb/wos_top_props.sv]
module wos_top_props #(
	parameter CW = 16
) (
	input logic            aclk,
	input logic            aresetn,
	input logic            s_axi_awready,
	input logic [1:0]      s_axi_bresp,
	input logic            s_axi_bvalid,
	input logic            s_axi_bready,
	input logic            s_axi_arvalid,
	input logic            s_axi_arready,
	input logic [31:0]     s_axi_rdata,
	input logic            s_axi_rvalid,
	input logic            s_axi_rready,
	input logic [2*CW-1:0] chan_code,
	input logic            conv_update,
	input logic            gen_begin_trigger,
	input logic            gen_sample_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	property p_reset_quiet;
		$rose(aresetn) |-> chan_code == 0 && !conv_update && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs busy after reset");
	property p_code_hold;
		!conv_update |-> $stable(chan_code);
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("channel code moved without update");
	// buffered two cycles after strobe, non-buffered one; software rises with bvalid
	property p_upd_cause;
		conv_update |-> $past(gen_sample_strobe) || $past(gen_sample_strobe, 2)
			|| $rose(s_axi_bvalid);
	endproperty
	a_upd_cause: assert property (p_upd_cause)
		else $error("update without strobe or command");
	property p_begin_pulse;
		gen_begin_trigger |=> !gen_begin_trigger;
	endproperty
	a_begin_pulse: assert property (p_begin_pulse)
		else $error("begin pulse longer than one cycle");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse)
		else $error("awready held two cycles");
	property p_r_after_ar;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_after_ar: assert property (p_r_after_ar)
		else $error("read data late");
	c_update: cover property (conv_update);
	c_begin: cover property (gen_begin_trigger);
	c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // wos_top_props

bind wos_top wos_top_props #(.CW(CW)) wos_top_props_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.chan_code(chan_code), .conv_update(conv_update),
	.gen_begin_trigger(gen_begin_trigger), .gen_sample_strobe(gen_sample_strobe)
);

// [tb/wos_host_model.sv]
module wos_host_model (
	input  logic        aclk,
	output logic [7:0]  s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  logic        s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic        s_axi_wvalid,
	input  logic        s_axi_wready,
	input  logic [1:0]  s_axi_bresp,
	input  logic        s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic        s_axi_arvalid,
	input  logic        s_axi_arready,
	input  logic [31:0] s_axi_rdata,
	input  logic [1:0]  s_axi_rresp,
	input  logic        s_axi_rvalid,
	output logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	// slow host: ready raised late so the slave must hold its answer
	int lag = 0;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready) begin
				s_axi_awvalid <= 0;
				aw_ok = 1;
			end
			if (!w_ok && s_axi_wready) begin
				s_axi_wvalid <= 0;
				w_ok = 1;
			end
		end
		repeat (lag) @(posedge aclk);
		s_axi_bready <= 1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		repeat (lag) @(posedge aclk);
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
endmodule // wos_host_model

// [tb/wos_tb_top.sv]
`include "wos_map.vh"
module wos_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 0, aresetn = 0, tbase = 0, tb_prev = 0, seen = 0;
	logic [20:0] src_v = '0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, chan_code, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        conv_update, gen_begin_trigger, gen_hold_trigger, gen_sample_strobe;
	int          miscompares = 0, total_checks = 0, cycles = 0;
	int          n_upd = 0, n_beg = 0, ticks = 0, first_ticks = 0, c, b;
	initial forever #25 aclk = ~aclk;
	always @(posedge aclk) tbase <= ~tbase;
	wos_host_model wos_host_model_inst (.*);
	wos_top #(.AW(8), .CW(16)) wos_top_inst (.*, .s_axi_wstrb(4'hf),
		.pft_in(src_v[5:0]), .trig_bus_in(src_v[13:6]),
		.acq_stop_reference_trigger(src_v[14]), .acq_begin_trigger(src_v[15]),
		.star_trigger(src_v[16]), .internal_trigger(src_v[20:17]),
		.gen_strobe_timebase(tbase));
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		tb_prev <= tbase;
		n_upd <= n_upd + conv_update;
		n_beg <= n_beg + gen_begin_trigger;
		if (gen_begin_trigger) ticks <= tbase && !tb_prev;
		else if (tbase && !tb_prev) ticks <= ticks + 1;
		if (gen_begin_trigger) seen <= 0;
		else if (gen_sample_strobe && !seen) begin
			first_ticks <= ticks;
			seen <= 1;
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input logic [7:0] a, input logic [31:0] v);
		wos_host_model_inst.wr(a, v, r);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, e);
		wos_host_model_inst.rd(a, d, r);
		chk(d & m, e);
	endtask
	task wu(input int t);
		for (int k = 0; k < 2000 && n_upd < t; k++) @(posedge aclk);
	endtask
	task pl(input int i);
		@(posedge aclk);
		src_v[i] <= 1;
		@(posedge aclk);
		src_v[i] <= 0;
		repeat (4) @(posedge aclk);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		wos_host_model_inst.lag = 3;
		rc(`WOS_REG_DIVISOR, 32'hffff_ffff, 32'h14);
		rc(`WOS_REG_DELAY, 32'hffff_ffff, 32'h2);
		rc(`WOS_REG_STATUS, 32'h0f, 32'h08);
		rc(8'h20, 32'hffff_ffff, 32'h0);
		chk(r, `WOS_RESP_SLVERR);
		w(8'h20, 32'h1);
		chk(r, `WOS_RESP_SLVERR);
		w(`WOS_REG_STATUS, 32'h1);
		chk(r, `WOS_RESP_OKAY);
		wos_host_model_inst.lag = 0;
		$display("test 1 done");
		b = n_upd;
		w(`WOS_REG_DATA, 32'h1234_5678);
		w(`WOS_REG_CTRL, 32'h08);
		repeat (4) @(posedge aclk);
		chk(n_upd - b, 1);
		chk(chan_code, 32'h1234_5678);
		$display("test 2 done");
		w(`WOS_REG_DIVISOR, 32'h2);
		w(`WOS_REG_COUNT, 32'h3);
		w(`WOS_REG_CTRL, 32'h20);
		for (c = 1; c <= 4; c++) w(`WOS_REG_DATA, 32'h1111_1111 * c);
		b = n_upd;
		w(`WOS_REG_CTRL, 32'h21);
		w(`WOS_REG_CTRL, 32'h22);
		wu(b + 3);
		repeat (20) @(posedge aclk);
		chk(n_upd - b, 3);
		chk(chan_code, 32'h3333_3333);
		chk(first_ticks, 2);
		rc(`WOS_REG_STATUS, 32'h01ff_0002, 32'h0001_0000);
		rc(`WOS_REG_ISSUED, 32'hffff_ffff, 32'h3);
		$display("test 3 done");
		// every external start source code (1 to 21) in turn, rising edge
		w(`WOS_REG_CTRL, 32'h10);
		for (c = 1; c <= 21; c++) begin
			w(`WOS_REG_SRC_SEL, c);
			b = n_beg;
			w(`WOS_REG_CTRL, 32'h11);
			src_v[c-1] <= 1;
			repeat (4) @(posedge aclk);
			chk(n_beg - b, 1);
			src_v <= '0;
			w(`WOS_REG_CTRL, 32'h14);
		end
		w(`WOS_REG_SRC_SEL, 32'h0003_060a);
		w(`WOS_REG_CTRL, 32'h450);
		src_v[9] <= 1;
		w(`WOS_REG_DATA, 32'haaaa_5555);
		b = n_beg;
		w(`WOS_REG_CTRL, 32'h451);
		repeat (3) @(posedge aclk);
		chk(n_beg - b, 0);
		src_v[9] <= 0;
		repeat (3) @(posedge aclk);
		chk(n_beg - b, 1);
		b = n_upd;
		for (c = 0; c < 3; c++) pl(2);
		chk(n_upd - b, 3);
		chk(chan_code, 32'haaaa_5555);
		src_v[5] <= 1;
		repeat (2) @(posedge aclk);
		chk(gen_hold_trigger, 1);
		pl(2);
		chk(n_upd - b, 3);
		src_v[5] <= 0;
		repeat (3) @(posedge aclk);
		chk(gen_hold_trigger, 0);
		chk(n_upd - b, 3);
		pl(2);
		chk(n_upd - b, 4);
		w(`WOS_REG_CTRL, 32'hc50);
		pl(2);
		chk(n_upd - b, 5);
		rc(`WOS_REG_STATUS, 32'h2, 32'h2);
		w(`WOS_REG_CTRL, 32'h454);
		rc(`WOS_REG_STATUS, 32'h2, 32'h0);
		$display("test 4 done");
		w(`WOS_REG_SRC_SEL, 32'h0);
		w(`WOS_REG_CTRL, 32'h4160);
		w(`WOS_REG_DATA, 32'h0a0a_0a0a);
		w(`WOS_REG_DATA, 32'h0b0b_0b0b);
		b = n_upd;
		w(`WOS_REG_CTRL, 32'h161);
		w(`WOS_REG_CTRL, 32'h162);
		w(`WOS_REG_DATA, 32'hdead_beef);
		rc(`WOS_REG_STATUS, 32'h40, 32'h40);
		wu(b + 3);
		chk(chan_code, 32'h0a0a_0a0a);
		w(`WOS_REG_CTRL, 32'h2004);
		rc(`WOS_REG_STATUS, 32'h46, 32'h0);
		$display("test 5 done");
		w(`WOS_REG_CTRL, 32'h4260);
		w(`WOS_REG_DATA, 32'h5a5a_a5a5);
		b = n_upd;
		w(`WOS_REG_CTRL, 32'h261);
		w(`WOS_REG_CTRL, 32'h262);
		repeat (40) @(posedge aclk);
		rc(`WOS_REG_STATUS, 32'h6, 32'h4);
		chk(n_upd - b, 1);
		w(`WOS_REG_CTRL, 32'h2000);
		rc(`WOS_REG_STATUS, 32'h4, 32'h0);
		$display("test 6 done");
		w(`WOS_REG_CTRL, 32'h4060);
		w(`WOS_REG_DATA, 32'h7777_1111);
		w(`WOS_REG_CTRL, 32'h61);
		b = n_upd;
		w(`WOS_REG_CTRL, 32'h62);
		w(`WOS_REG_DATA, 32'h7777_2222);
		wu(b + 2);
		chk(chan_code, 32'h7777_2222);
		repeat (10) @(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rc(`WOS_REG_STATUS, 32'h0f, 32'h08);
		chk(chan_code, 32'h0);
		$display("test 7 done");
		end_of_test();
	end
endmodule // wos_tb_top
